// ===== design/rscr_cal_cnt.sv
`include "rscr_regs.svh"
// Counting registers carry no reset at all: every reset, power-on included,
// leaves them as they were; counting goes on while the chip is held, except after power-on, which clears the run bit.
module rscr_cal_cnt (
	input wire logic clk_i,
	input wire logic tick_i,
	input wire logic run_i,
	input wire logic wr_i,
	input wire logic [3:0] addr_i,
	input wire logic [7:0] wdata_i,
	output rscr_pkg::rscr_cnt_t cnt_o
);
	rscr_pkg::rscr_cnt_t st;
	rscr_pkg::rscr_cnt_t next_st;

	function automatic logic [8:0] step(input logic [7:0] v, input logic [7:0] lo,
			input logic [7:0] hi, input logic en);
		if (!en) begin
			step = {1'b0, v};
		end else if (v >= hi) begin
			step = {1'b1, lo};
		end else begin
			step = {1'b0, v + 8'h01};
		end
	endfunction : step

	always_comb begin
		logic c_min;
		logic c_hour;
		logic c_day;
		logic c_month;
		logic c_year;
		logic unused_wrap;
		c_min = 1'b0;
		c_hour = 1'b0;
		c_day = 1'b0;
		c_month = 1'b0;
		c_year = 1'b0;
		unused_wrap = 1'b0;
		next_st = st;
		{c_min, next_st[`RSCR_ADDR_SEC]} = step(st[`RSCR_ADDR_SEC], `RSCR_ZERO,
			`RSCR_SEC_MAX, tick_i && run_i);
		{c_hour, next_st[`RSCR_ADDR_MIN]} = step(st[`RSCR_ADDR_MIN], `RSCR_ZERO,
			`RSCR_MIN_MAX, c_min);
		{c_day, next_st[`RSCR_ADDR_HOUR]} = step(st[`RSCR_ADDR_HOUR], `RSCR_ZERO,
			`RSCR_HOUR_MAX, c_hour);
		{unused_wrap, next_st[`RSCR_ADDR_WEEK]} = step(st[`RSCR_ADDR_WEEK], `RSCR_ZERO,
			`RSCR_WEEK_MAX, c_day);
		// Month lengths are not modelled: day wraps at 31 in every month
		{c_month, next_st[`RSCR_ADDR_DAY]} = step(st[`RSCR_ADDR_DAY], `RSCR_DAY_MIN,
			`RSCR_DAY_MAX, c_day);
		{c_year, next_st[`RSCR_ADDR_MONTH]} = step(st[`RSCR_ADDR_MONTH], `RSCR_MONTH_MIN,
			`RSCR_MONTH_MAX, c_month);
		{unused_wrap, next_st[`RSCR_ADDR_YEAR]} = step(st[`RSCR_ADDR_YEAR], `RSCR_ZERO,
			`RSCR_YEAR_MAX, c_year);
		// A write wins over a tick in the same cycle
		if (wr_i && addr_i <= `RSCR_ADDR_ALM_WEEK) begin
			next_st[addr_i] = wdata_i;
		end
	end

	always_ff @(posedge clk_i) begin
		st <= next_st;
	end

	assign cnt_o = st;
endmodule : rscr_cal_cnt

// ===== design/rscr_pkg.sv
`include "rscr_regs.svh"
package rscr_pkg;
	typedef struct packed {
		logic [7:0] wdt;
		logic [7:0] lvd;
		logic [7:0] clk;
	} rscr_opt_s;

	typedef struct packed {
		logic [7:0] calendar_ctrl_a;
		logic [7:0] calendar_ctrl_b;
		logic [7:0] subcount_correction;
	} rscr_sys_s;

	typedef logic [`RSCR_CNT_WORDS-1:0][7:0] rscr_cnt_t;

	typedef enum logic [1:0] {
		RSCR_RUN = 2'h0,
		RSCR_HOLD = 2'h1,
		RSCR_STRETCH = 2'h3
	} rscr_seq_e;

	typedef struct packed {
		rscr_seq_e seq;
		logic [7:0] stretch;
		logic lvd_low;
		logic [7:0] reset_flag_reg;
		rscr_opt_s opt;
		logic opt_loaded;
		rscr_sys_s sys;
		logic [7:0] flag_rdata;
		logic [7:0] cal_rdata;
	} rscr_top_s;
endpackage : rscr_pkg

// ===== design/rscr_regs.svh
`ifndef RSCR_REGS_SVH
`define RSCR_REGS_SVH
// Summary of operation
// - Drop detector in reset mode holds reset
// - Hysteresis: trip below 2.75 V, release 2.81 V
// - Drop reset sets supply-drop flag to one
// - Power-on reset clears whole flag register
// - Reading flags returns them, then clears them
// - Power-on reset restores calendar system registers
// - Power-on reset leaves calendar counters untouched
// - Other resets keep all calendar registers
// - Calendar keeps counting during drop reset
// - Watchdog option byte 01101110B stops watchdog
// - Detector option byte 01111111B selects reset mode
// - Clock option byte 11100000B selects 24 MHz
// - Supply-drop flag sits at bit zero

`define RSCR_CLK_NS 10
`define RSCR_RST_STRETCH_NS 160
`define RSCR_RST_STRETCH_CYC ((`RSCR_RST_STRETCH_NS + `RSCR_CLK_NS - 1) / `RSCR_CLK_NS)
`define RSCR_LVD_RISE_MV 2810
`define RSCR_LVD_FALL_MV 2750

`define RSCR_FLAG_SUPPLY_DROP 0
`define RSCR_FLAG_ILLEGAL_ACC 1
`define RSCR_FLAG_PARITY 2
`define RSCR_FLAG_WDT 4
`define RSCR_FLAG_TRAP 7
`define RSCR_FLAG_RST 8'h00

`define RSCR_OPT_WDT_ON_BIT 4
`define RSCR_OPT_LVD_MODE 1:0
`define RSCR_LVD_MODE_RESET 2'h3
`define RSCR_OPT_LVD_LEVEL 7:2
`define RSCR_OPT_CLK_FREQ 4:0
`define RSCR_OPT_CLK_MODE 7:6
`define RSCR_CLK_MODE_HS 2'h3
`define RSCR_OPT_WDT_DOC 8'h6E
`define RSCR_OPT_LVD_DOC 8'h7F
`define RSCR_OPT_CLK_DOC 8'hE0
`define RSCR_OPT_RST 8'h00

`define RSCR_ADDR_SEC 4'h0
`define RSCR_ADDR_MIN 4'h1
`define RSCR_ADDR_HOUR 4'h2
`define RSCR_ADDR_DAY 4'h3
`define RSCR_ADDR_WEEK 4'h4
`define RSCR_ADDR_MONTH 4'h5
`define RSCR_ADDR_YEAR 4'h6
`define RSCR_ADDR_ALM_MIN 4'h7
`define RSCR_ADDR_ALM_HOUR 4'h8
`define RSCR_ADDR_ALM_WEEK 4'h9
`define RSCR_ADDR_CTRL_A 4'hA
`define RSCR_ADDR_CTRL_B 4'hB
`define RSCR_ADDR_SUBCNT 4'hC
`define RSCR_CNT_WORDS 10
`define RSCR_SYS_RST 8'h00
`define RSCR_CTRL_A_RUN 7

`define RSCR_SEC_MAX 8'h3B
`define RSCR_MIN_MAX 8'h3B
`define RSCR_HOUR_MAX 8'h17
`define RSCR_DAY_MIN 8'h01
`define RSCR_DAY_MAX 8'h1F
`define RSCR_WEEK_MAX 8'h06
`define RSCR_MONTH_MIN 8'h01
`define RSCR_MONTH_MAX 8'h0C
`define RSCR_YEAR_MAX 8'h63
`define RSCR_ZERO 8'h00
`endif

// ===== design/rscr_sync.sv
module rscr_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [WIDTH-1:0] d_i,
	output logic [WIDTH-1:0] q_o
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] q;
	} rscr_sync_s;

	rscr_sync_s st;
	rscr_sync_s next_st;

	always_comb begin
		next_st.meta = d_i;
		next_st.q = st.meta;
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			st <= {RST_VAL, RST_VAL};
		end else begin
			st <= next_st;
		end
	end

	assign q_o = st.q;
endmodule : rscr_sync

// ===== design/rscr_top.sv
`include "rscr_regs.svh"
module rscr_top (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic vdd_above_fall_i,
	input wire logic vdd_above_rise_i,
	input wire logic ext_reset_n_i,
	input wire logic wdt_expire_i,
	input wire logic illegal_access_i,
	input wire logic parity_error_i,
	input wire logic trap_i,
	input wire rscr_pkg::rscr_opt_s opt_bytes_i,
	input wire logic flag_rd_i,
	output logic [7:0] flag_rdata_o,
	input wire logic cal_wr_i,
	input wire logic cal_rd_i,
	input wire logic [3:0] cal_addr_i,
	input wire logic [7:0] cal_wdata_i,
	output logic [7:0] cal_rdata_o,
	input wire logic sec_tick_i,
	output logic chip_reset_o,
	output logic lvd_reset_mode_o,
	output logic [5:0] lvd_level_code_o,
	output logic wdt_run_o,
	output logic [4:0] hoco_freq_code_o,
	output logic hs_main_mode_o
);
	localparam logic [7:0] STRETCH_LAST = 8'(`RSCR_RST_STRETCH_CYC - 1);

	rscr_pkg::rscr_top_s st;
	rscr_pkg::rscr_top_s next_st;
	rscr_pkg::rscr_cnt_t cnt;
	logic above_fall;
	logic above_rise;
	logic ext_reset_n;
	logic lvd_mode;
	logic src_active;
	logic cnt_wr;
	logic cal_run;

	// Comparators and the reset pin are asynchronous to clk_i
	rscr_sync #(
		.WIDTH(3),
		.RST_VAL(3'h7)
	) u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i({vdd_above_fall_i, vdd_above_rise_i, ext_reset_n_i}),
		.q_o({above_fall, above_rise, ext_reset_n})
	);

	assign lvd_mode = st.opt_loaded &&
		(st.opt.lvd[`RSCR_OPT_LVD_MODE] == `RSCR_LVD_MODE_RESET);
	assign src_active = st.lvd_low || !ext_reset_n || wdt_expire_i ||
		illegal_access_i || parity_error_i || trap_i;
	assign chip_reset_o = st.lvd_low || (st.seq != rscr_pkg::RSCR_RUN);
	assign cal_run = st.sys.calendar_ctrl_a[`RSCR_CTRL_A_RUN];
	// Software cannot run while the chip is held, so writes are dropped then
	assign cnt_wr = cal_wr_i && !chip_reset_o;

	always_comb begin
		next_st = st;

		// Option bytes are sampled once after power-on release, like straps
		if (!st.opt_loaded) begin
			next_st.opt = opt_bytes_i;
			next_st.opt_loaded = 1'b1;
		end

		// Trip below the falling level, release only above the rising level
		if (!lvd_mode) begin
			next_st.lvd_low = 1'b0;
		end else if (!st.lvd_low && !above_fall) begin
			next_st.lvd_low = 1'b1;
		end else if (st.lvd_low && above_rise) begin
			next_st.lvd_low = 1'b0;
		end

		case (st.seq)
			rscr_pkg::RSCR_RUN: begin
				if (src_active) begin
					next_st.seq = rscr_pkg::RSCR_HOLD;
				end
			end
			rscr_pkg::RSCR_HOLD: begin
				if (!src_active) begin
					next_st.seq = rscr_pkg::RSCR_STRETCH;
					next_st.stretch = STRETCH_LAST;
				end
			end
			rscr_pkg::RSCR_STRETCH: begin
				if (src_active) begin
					next_st.seq = rscr_pkg::RSCR_HOLD;
				end else if (st.stretch == 8'h00) begin
					next_st.seq = rscr_pkg::RSCR_RUN;
				end else begin
					next_st.stretch = st.stretch - 8'h01;
				end
			end
			default: begin
				next_st.seq = rscr_pkg::RSCR_HOLD;
			end
		endcase

		// Clear on read first, then sources set: a set never gets lost
		if (flag_rd_i) begin
			next_st.flag_rdata = st.reset_flag_reg;
			next_st.reset_flag_reg = `RSCR_FLAG_RST;
		end
		if (st.lvd_low) begin
			next_st.reset_flag_reg[`RSCR_FLAG_SUPPLY_DROP] = 1'b1;
		end
		if (wdt_expire_i) begin
			next_st.reset_flag_reg[`RSCR_FLAG_WDT] = 1'b1;
		end
		if (illegal_access_i) begin
			next_st.reset_flag_reg[`RSCR_FLAG_ILLEGAL_ACC] = 1'b1;
		end
		if (parity_error_i) begin
			next_st.reset_flag_reg[`RSCR_FLAG_PARITY] = 1'b1;
		end
		if (trap_i) begin
			next_st.reset_flag_reg[`RSCR_FLAG_TRAP] = 1'b1;
		end

		if (cnt_wr) begin
			case (cal_addr_i)
				`RSCR_ADDR_CTRL_A: next_st.sys.calendar_ctrl_a = cal_wdata_i;
				`RSCR_ADDR_CTRL_B: next_st.sys.calendar_ctrl_b = cal_wdata_i;
				`RSCR_ADDR_SUBCNT: next_st.sys.subcount_correction = cal_wdata_i;
				default: begin
				end
			endcase
		end

		if (cal_rd_i) begin
			case (cal_addr_i)
				`RSCR_ADDR_CTRL_A: next_st.cal_rdata = st.sys.calendar_ctrl_a;
				`RSCR_ADDR_CTRL_B: next_st.cal_rdata = st.sys.calendar_ctrl_b;
				`RSCR_ADDR_SUBCNT: next_st.cal_rdata = st.sys.subcount_correction;
				default: begin
					if (cal_addr_i <= `RSCR_ADDR_ALM_WEEK) begin
						next_st.cal_rdata = cnt[cal_addr_i];
					end else begin
						next_st.cal_rdata = 8'h00;
					end
				end
			endcase
		end
	end

	// rst_i is the power-on reset; other sources drive chip_reset_o and, except the pin, set flags, but reset no state here
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			st.seq <= rscr_pkg::RSCR_HOLD;
			st.stretch <= STRETCH_LAST;
			st.lvd_low <= 1'b0;
			st.reset_flag_reg <= `RSCR_FLAG_RST;
			st.opt <= {`RSCR_OPT_RST, `RSCR_OPT_RST, `RSCR_OPT_RST};
			st.opt_loaded <= 1'b0;
			st.sys <= {`RSCR_SYS_RST, `RSCR_SYS_RST, `RSCR_SYS_RST};
			st.flag_rdata <= 8'h00;
			st.cal_rdata <= 8'h00;
		end else begin
			st <= next_st;
		end
	end

	rscr_cal_cnt u_cnt (
		.clk_i(clk_i),
		.tick_i(sec_tick_i),
		.run_i(cal_run),
		.wr_i(cnt_wr),
		.addr_i(cal_addr_i),
		.wdata_i(cal_wdata_i),
		.cnt_o(cnt)
	);

	assign flag_rdata_o = st.flag_rdata;
	assign cal_rdata_o = st.cal_rdata;
	assign lvd_reset_mode_o = lvd_mode;
	assign lvd_level_code_o = st.opt.lvd[`RSCR_OPT_LVD_LEVEL];
	assign wdt_run_o = st.opt_loaded && st.opt.wdt[`RSCR_OPT_WDT_ON_BIT];
	assign hoco_freq_code_o = st.opt.clk[`RSCR_OPT_CLK_FREQ];
	assign hs_main_mode_o = st.opt_loaded &&
		(st.opt.clk[`RSCR_OPT_CLK_MODE] == `RSCR_CLK_MODE_HS);

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	property p_lvd_trip;
		lvd_mode && !st.lvd_low && !above_fall |=> st.lvd_low ##0 chip_reset_o;
	endproperty
	a_lvd_trip: assert property (p_lvd_trip) else $error("drop reset not taken");

	property p_lvd_release;
		lvd_mode && st.lvd_low && above_rise |=> !st.lvd_low;
	endproperty
	a_lvd_release: assert property (p_lvd_release) else $error("drop reset held");

	property p_hysteresis;
		st.lvd_low && lvd_mode && !above_rise |=> st.lvd_low;
	endproperty
	a_hysteresis: assert property (p_hysteresis) else $error("released early");

	property p_low_resets;
		st.lvd_low |-> chip_reset_o;
	endproperty
	a_low_resets: assert property (p_low_resets) else $error("no chip reset");

	property p_flag_set;
		st.lvd_low |=> st.reset_flag_reg[`RSCR_FLAG_SUPPLY_DROP];
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("drop flag not set");

	property p_read_clear;
		flag_rd_i && !st.lvd_low |=>
			(flag_rdata_o == $past(st.reset_flag_reg)) &&
			!st.reset_flag_reg[`RSCR_FLAG_SUPPLY_DROP];
	endproperty
	a_read_clear: assert property (p_read_clear) else $error("read-clear wrong");

	property p_flag_hold;
		!flag_rd_i && st.reset_flag_reg[`RSCR_FLAG_SUPPLY_DROP] |=>
			st.reset_flag_reg[`RSCR_FLAG_SUPPLY_DROP];
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("drop flag lost");

	property p_por;
		disable iff (1'b0)
		rst_i |-> (st.reset_flag_reg == `RSCR_FLAG_RST) &&
			(st.sys == {`RSCR_SYS_RST, `RSCR_SYS_RST, `RSCR_SYS_RST});
	endproperty
	a_por: assert property (p_por) else $error("power-on state wrong");

	property p_sys_keep;
		chip_reset_o |=> $stable(st.sys);
	endproperty
	a_sys_keep: assert property (p_sys_keep) else $error("system regs changed");

	property p_count_in_reset;
		chip_reset_o && cal_run && sec_tick_i |=>
			cnt[`RSCR_ADDR_SEC] != $past(cnt[`RSCR_ADDR_SEC]);
	endproperty
	a_count_in_reset: assert property (p_count_in_reset) else $error("count stopped");

	property p_wdt_stop;
		st.opt_loaded && st.opt.wdt == `RSCR_OPT_WDT_DOC |-> !wdt_run_o;
	endproperty
	a_wdt_stop: assert property (p_wdt_stop) else $error("watchdog running");

	property p_lvd_opt;
		st.opt_loaded && st.opt.lvd == `RSCR_OPT_LVD_DOC |-> lvd_reset_mode_o;
	endproperty
	a_lvd_opt: assert property (p_lvd_opt) else $error("detector not in reset mode");

	property p_clk_opt;
		st.opt_loaded && st.opt.clk == `RSCR_OPT_CLK_DOC |->
			hs_main_mode_o && hoco_freq_code_o == 5'h00;
	endproperty
	a_clk_opt: assert property (p_clk_opt) else $error("clock option wrong");

	property p_src_holds;
		src_active |=> chip_reset_o;
	endproperty
	a_src_holds: assert property (p_src_holds) else $error("reset source not held");

	property p_opt_once;
		st.opt_loaded |=> $stable(st.opt);
	endproperty
	a_opt_once: assert property (p_opt_once) else $error("option bytes changed");

	property p_flag_rdata_hold;
		!flag_rd_i |=> $stable(flag_rdata_o);
	endproperty
	a_flag_rdata_hold: assert property (p_flag_rdata_hold) else $error("flag data moved");

	property p_cal_rdata_hold;
		!cal_rd_i |=> $stable(cal_rdata_o);
	endproperty
	a_cal_rdata_hold: assert property (p_cal_rdata_hold) else $error("calendar data moved");

	property p_cov_drop;
		!st.lvd_low ##1 st.lvd_low ##[1:1000] !chip_reset_o;
	endproperty
	c_cov_drop: cover property (p_cov_drop);

	property p_cov_read;
		st.reset_flag_reg[`RSCR_FLAG_SUPPLY_DROP] && flag_rd_i;
	endproperty
	c_cov_read: cover property (p_cov_read);

	property p_cov_tick;
		chip_reset_o && cal_run && sec_tick_i;
	endproperty
	c_cov_tick: cover property (p_cov_tick);

	property p_cov_src;
		wdt_expire_i || illegal_access_i || parity_error_i || trap_i;
	endproperty
	c_cov_src: cover property (p_cov_src);

	property p_cov_pin;
		!ext_reset_n ##1 ext_reset_n;
	endproperty
	c_cov_pin: cover property (p_cov_pin);
endmodule : rscr_top

// ===== tb/test_rscr_top.sv
`include "rscr_regs.svh"
module test_rscr_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_i = 1'b0;
	logic rst_i = 1'b0;
	logic fall_ok = 1'b1;
	logic rise_ok = 1'b1;
	logic ext_n = 1'b1;
	logic [3:0] req = 4'h0;
	logic flag_rd = 1'b0;
	logic cal_wr = 1'b0;
	logic cal_rd = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic tick = 1'b0;
	logic [7:0] flag_q;
	logic [7:0] cal_q;
	logic chip_rst;
	logic lvd_mode;
	logic wdt_run;
	logic hs_mode;
	logic [5:0] lvd_level;
	logic [4:0] freq;
	logic [7:0] rd;
	logic [7:0] exp_sec;
	logic [7:0] vals [13];
	int bits [4];
	int miscompares = 0;
	int check_count = 0;
	rscr_pkg::rscr_opt_s opt = {`RSCR_OPT_WDT_DOC, `RSCR_OPT_LVD_DOC, `RSCR_OPT_CLK_DOC};

	always #5 clk_i = ~clk_i;

	rscr_top u_rscr_top (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.vdd_above_fall_i(fall_ok),
		.vdd_above_rise_i(rise_ok),
		.ext_reset_n_i(ext_n),
		.wdt_expire_i(req[0]),
		.illegal_access_i(req[1]),
		.parity_error_i(req[2]),
		.trap_i(req[3]),
		.opt_bytes_i(opt),
		.flag_rd_i(flag_rd),
		.flag_rdata_o(flag_q),
		.cal_wr_i(cal_wr),
		.cal_rd_i(cal_rd),
		.cal_addr_i(addr),
		.cal_wdata_i(wdata),
		.cal_rdata_o(cal_q),
		.sec_tick_i(tick),
		.chip_reset_o(chip_rst),
		.lvd_reset_mode_o(lvd_mode),
		.lvd_level_code_o(lvd_level),
		.wdt_run_o(wdt_run),
		.hoco_freq_code_o(freq),
		.hs_main_mode_o(hs_mode)
	);

	task automatic conclude();
		if (miscompares == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : conclude

	task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
		end
	endtask : check

	task automatic cal_write(input logic [3:0] a, input logic [7:0] d);
		@(negedge clk_i);
		cal_wr = 1'b1;
		addr = a;
		wdata = d;
		@(negedge clk_i);
		cal_wr = 1'b0;
	endtask : cal_write

	task automatic cal_read(input logic [3:0] a, output logic [7:0] d);
		@(negedge clk_i);
		cal_rd = 1'b1;
		addr = a;
		@(negedge clk_i);
		cal_rd = 1'b0;
		@(negedge clk_i);
		d = cal_q;
	endtask : cal_read

	task automatic flag_read(output logic [7:0] d);
		@(negedge clk_i);
		flag_rd = 1'b1;
		@(negedge clk_i);
		flag_rd = 1'b0;
		@(negedge clk_i);
		d = flag_q;
	endtask : flag_read

	// Bounded wait; a hang counts as a miscompare and ends the run
	task automatic wait_rst(input logic lvl);
		int n;
		n = 0;
		while (chip_rst !== lvl && n < 60) begin
			@(negedge clk_i);
			n++;
		end
		if (chip_rst !== lvl) begin
			miscompares++;
			$display("unexpected chip_reset_o: expected %b, seen %b", lvl, chip_rst);
			conclude();
		end
	endtask : wait_rst

	task automatic tick_sec();
		@(negedge clk_i);
		tick = 1'b1;
		@(negedge clk_i);
		tick = 1'b0;
	endtask : tick_sec

	// System registers sit at 10..12; after power-on they must read zero
	task automatic check_all(input logic sys_zero);
		logic [7:0] e;
		for (int a = 0; a < 13; a++) begin
			e = (a == 0) ? exp_sec : ((a >= 10 && sys_zero) ? `RSCR_SYS_RST : vals[a]);
			cal_read(a[3:0], rd);
			check("calendar register", e, rd);
		end
	endtask : check_all

	// Boot firmware: one flag read, used for calendar setup and handed back to the caller
	task automatic boot(output logic [7:0] flags);
		logic drop_seen;
		flag_read(flags);
		drop_seen = flags[`RSCR_FLAG_SUPPLY_DROP];
		if (!drop_seen) begin
			for (int a = 0; a < 13; a++) begin
				cal_write(a[3:0], vals[a]);
			end
		end
	endtask : boot

	initial begin
		vals = '{8'h10, 8'h14, 8'h05, 8'h0C, 8'h03, 8'h07, 8'h12, 8'h1E, 8'h0A, 8'h02,
			8'h80, 8'h01, 8'h21};
		bits = '{`RSCR_FLAG_WDT, `RSCR_FLAG_ILLEGAL_ACC, `RSCR_FLAG_PARITY, `RSCR_FLAG_TRAP};
		// Raised after time zero so the asynchronous reset sees a real edge
		#1 rst_i = 1'b1;
		repeat (2) @(negedge clk_i);
		rst_i = 1'b0;
		@(negedge clk_i);
		check("wdt_run_o", 8'h00, {7'h00, wdt_run});
		check("lvd_reset_mode_o", 8'h01, {7'h00, lvd_mode});
		check("lvd_level_code_o", 8'h1F, {2'h0, lvd_level});
		check("hs_main_mode_o", 8'h01, {7'h00, hs_mode});
		check("hoco_freq_code_o", 8'h00, {3'h0, freq});
		wait_rst(1'b0);
		boot(rd);
		check("reset_flag_reg", 8'h00, rd);
		exp_sec = vals[0];
		cal_write(4'hD, 8'h55);
		cal_read(4'hD, rd);
		check("unmapped address", 8'h00, rd);
		tick_sec();
		exp_sec++;
		check_all(1'b0);
		// Supply drops below both levels, then sits between them
		fall_ok = 1'b0;
		rise_ok = 1'b0;
		wait_rst(1'b1);
		tick_sec();
		exp_sec++;
		fall_ok = 1'b1;
		repeat (30) @(negedge clk_i);
		check("chip_reset_o", 8'h01, {7'h00, chip_rst});
		// Writes are dropped while the chip is held
		cal_write(4'h0, 8'h00);
		rise_ok = 1'b1;
		wait_rst(1'b0);
		boot(rd);
		check("supply_drop_reset_flag", 8'h01, rd);
		flag_read(rd);
		check("reset_flag_reg", 8'h00, rd);
		check_all(1'b0);
		for (int i = 0; i < 4; i++) begin
			@(negedge clk_i);
			req[i] = 1'b1;
			@(negedge clk_i);
			req = 4'h0;
			wait_rst(1'b1);
			wait_rst(1'b0);
			flag_read(rd);
			check("reset_flag_reg", 8'h01 << bits[i], rd);
			check_all(1'b0);
		end
		ext_n = 1'b0;
		wait_rst(1'b1);
		ext_n = 1'b1;
		wait_rst(1'b0);
		flag_read(rd);
		check("reset_flag_reg", 8'h00, rd);
		check_all(1'b0);
		// Drop flag set again, then power-on must clear it
		fall_ok = 1'b0;
		rise_ok = 1'b0;
		wait_rst(1'b1);
		fall_ok = 1'b1;
		rise_ok = 1'b1;
		// Other option values take effect only at the next power-on
		opt = {8'h10, 8'h7C, 8'h00};
		@(negedge clk_i);
		rst_i = 1'b1;
		repeat (2) @(negedge clk_i);
		rst_i = 1'b0;
		flag_read(rd);
		check("reset_flag_reg", 8'h00, rd);
		check("wdt_run_o", 8'h01, {7'h00, wdt_run});
		check("lvd_reset_mode_o", 8'h00, {7'h00, lvd_mode});
		check("hs_main_mode_o", 8'h00, {7'h00, hs_mode});
		check_all(1'b1);
		// Outside reset mode a supply drop neither holds the chip nor flags
		wait_rst(1'b0);
		fall_ok = 1'b0;
		rise_ok = 1'b0;
		repeat (5) @(negedge clk_i);
		check("chip_reset_o", 8'h00, {7'h00, chip_rst});
		flag_read(rd);
		check("reset_flag_reg", 8'h00, rd);
		conclude();
	end
endmodule : test_rscr_top
